// File: include/eca_defines.svh
// named constants for the electrode charge and auto-configuration block
// assumes a 200 MHz core clock and a register back end addressed by index
`ifndef ECA_DEFINES_SVH
`define ECA_DEFINES_SVH

`define ECA_NUM_ELE        12
`define ECA_NUM_PAIR       6
`define ECA_IDX_W          5
`define ECA_ELE_W          4

// register indices
`define ECA_IDX_CUR0       5'h00
`define ECA_IDX_TIME0      5'h0C
`define ECA_IDX_UPPER      5'h12
`define ECA_IDX_TARGET     5'h13
`define ECA_IDX_LOWER      5'h14

// reset values
`define ECA_RST_CUR        6'h00
`define ECA_RST_TPAIR      7'h00
`define ECA_RST_LIMIT      8'h00

// field layout of a charge time pair
`define ECA_TPAIR_HI_MSB   6
`define ECA_TPAIR_HI_LSB   4
`define ECA_TPAIR_LO_MSB   2
`define ECA_TPAIR_LO_LSB   0

`define ECA_CUR_MAX        6'h3F
`define ECA_CUR_MIN        6'h01
`define ECA_CODE_OFF       3'h0

// charge time: code 1 is the shortest step, each code above doubles it
`define ECA_CLK_PERIOD_PS  5000
`define ECA_T_STEP_PS      500000
`define ECA_T_STEP_CYC     ((`ECA_T_STEP_PS + `ECA_CLK_PERIOD_PS - 1) / `ECA_CLK_PERIOD_PS)

`endif

// File: include/eca_pkg.sv
// types shared by the electrode charge and auto-configuration block
// assumes eca_defines.svh is on the include path
`include "eca_defines.svh"

package eca_pkg;

  typedef enum logic [1:0] {
    ECA_IDLE,
    ECA_INIT,
    ECA_RECONF,
    ECA_DONE
  } eca_phase_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] ele;
    logic [7:0] baseline;
  } eca_meas_t;

  typedef struct packed {
    logic        enable;
    logic [5:0]  current;
    logic [2:0]  time_code;
    logic [12:0] cycles;
  } eca_drive_t;

endpackage

// File: design/eca_charge_autoconf.sv
// charge settings, search limits and auto-configuration search per electrode
// assumes a register back end on the core clock and a front end that reports
// one baseline per electrode measurement on the same clock
//
// Contract
// - each electrode has a 6-bit charge current code and code zero disables its charging.
// - a current code of 1 to 63 charges and discharges with that many microamperes.
// - each time pair register holds two 3-bit codes in 6:4 and 2:0, zero meaning the global time.
// - an automatic search picks each electrode's charge current itself.
// - the 8-bit upper limit is the ceiling of the baseline search.
// - the 8-bit target level is the level the baseline search aims for.
// - the 8-bit lower limit is the floor of the baseline search.
// - configuration runs only with its enable set, reconfiguration only with its own enable; a running reconfiguration goes on after reconf_enable clears.
// - with reconfiguration enabled, a baseline outside the limits restarts the search.
// - a failed search sets the electrode's out-of-range flag and a flag naming its cause.
// - a zero electrode time code takes the global charge time from the filter settings.
`timescale 1ns/1ps
`default_nettype none
`include "eca_defines.svh"

module eca_charge_autoconf
  import eca_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [4:0]              reg_idx,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    autoconf_enable,
  input  wire logic                    reconf_enable,
  input  wire logic [2:0]              charge_time_code,
  input  wire logic                    fail_flags_clear,
  input  wire eca_meas_t               meas,
  input  wire logic [3:0]              drive_sel,
  output eca_drive_t                   drive,
  output logic [`ECA_NUM_ELE-1:0]      out_of_range_flag,
  output logic                         initial_conf_fail_flag,
  output logic                         reconf_fail_flag
);

  logic [5:0]       cur_q   [`ECA_NUM_ELE];
  logic [5:0]       cur_d   [`ECA_NUM_ELE];
  logic [6:0]       tpair_q [`ECA_NUM_PAIR];
  logic [6:0]       tpair_d [`ECA_NUM_PAIR];
  eca_phase_t       phase_q [`ECA_NUM_ELE];
  eca_phase_t       phase_d [`ECA_NUM_ELE];
  logic [`ECA_NUM_ELE-1:0] rise_q, rise_d, oor_q, oor_d;
  logic [7:0]       upper_q, upper_d, target_q, target_d, lower_q, lower_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             initial_conf_fail_flag_q, initial_conf_fail_flag_d, reconf_fail_flag_q, reconf_fail_flag_d;
  eca_drive_t       drive_q, drive_d;

  // electrode's own 3-bit time code, odd electrodes in the high field
  function automatic logic [2:0] own_time(input logic [6:0] pair, input logic odd);
    own_time = odd ? pair[`ECA_TPAIR_HI_MSB:`ECA_TPAIR_HI_LSB]
                   : pair[`ECA_TPAIR_LO_MSB:`ECA_TPAIR_LO_LSB];
  endfunction

  // clock cycles of one charge phase for a time code
  function automatic logic [12:0] time_cycles(input logic [2:0] code);
    logic [12:0] step;
    step = 13'(`ECA_T_STEP_CYC);
    time_cycles = (code == `ECA_CODE_OFF) ? 13'h0000 : 13'(step << (code - 3'h1));
  endfunction

  always_comb begin
    logic [3:0] e;
    logic [7:0] b;
    logic       fail;
    e = meas.ele;
    b = meas.baseline;
    fail = 1'b0;
    cur_d = cur_q;
    tpair_d = tpair_q;
    phase_d = phase_q;
    rise_d = rise_q;
    oor_d = oor_q;
    upper_d = upper_q;
    target_d = target_q;
    lower_d = lower_q;
    initial_conf_fail_flag_d = initial_conf_fail_flag_q && !fail_flags_clear;
    reconf_fail_flag_d = reconf_fail_flag_q && !fail_flags_clear;
    rdata_d = rdata_q;
    // host writes; upper bits are dropped on the way in
    if (reg_wr) begin
      if (reg_idx < `ECA_IDX_TIME0) begin
        cur_d[reg_idx[3:0]] = reg_wdata[5:0];
      end else if (reg_idx < `ECA_IDX_UPPER) begin
        tpair_d[3'(reg_idx - `ECA_IDX_TIME0)] = reg_wdata[6:0];
      end else if (reg_idx == `ECA_IDX_UPPER) begin
        upper_d = reg_wdata;
      end else if (reg_idx == `ECA_IDX_TARGET) begin
        target_d = reg_wdata;
      end else if (reg_idx == `ECA_IDX_LOWER) begin
        lower_d = reg_wdata;
      end
    end
    // enable drops every electrode back to idle; flags are kept for the host
    for (int i = 0; i < `ECA_NUM_ELE; i++) begin
      if (!autoconf_enable) begin
        phase_d[i] = ECA_IDLE;
      end else if (phase_q[i] == ECA_IDLE) begin
        phase_d[i] = ECA_INIT;
        rise_d[i] = 1'b0;
        oor_d[i] = 1'b0;
        if (cur_q[i] == `ECA_RST_CUR) begin
          cur_d[i] = `ECA_CUR_MIN;
        end
      end
    end
    // the search step follows the host write, so an engine result wins a collision
    if (autoconf_enable && meas.valid && e < 4'(`ECA_NUM_ELE)) begin
      unique case (phase_q[e])
        ECA_INIT, ECA_RECONF: begin
          if (b > upper_q) begin
            if (cur_q[e] == `ECA_CUR_MIN) begin
              fail = 1'b1;
            end else begin
              cur_d[e] = cur_q[e] - 6'h01;
              // stepped past the ceiling from inside the window: settle one below
              if (rise_q[e]) begin
                phase_d[e] = ECA_DONE;
              end
            end
          end else if (b < lower_q) begin
            if (cur_q[e] == `ECA_CUR_MAX) begin
              fail = 1'b1;
            end else begin
              cur_d[e] = cur_q[e] + 6'h01;
            end
          end else if (b < target_q && cur_q[e] != `ECA_CUR_MAX) begin
            cur_d[e] = cur_q[e] + 6'h01;
            rise_d[e] = 1'b1;
          end else begin
            phase_d[e] = ECA_DONE;
          end
          if (fail) begin
            phase_d[e] = ECA_DONE;
            oor_d[e] = 1'b1;
            if (phase_q[e] == ECA_INIT) begin
              initial_conf_fail_flag_d = 1'b1;
            end else begin
              reconf_fail_flag_d = 1'b1;
            end
          end
        end
        ECA_DONE: begin
          if (reconf_enable && (b > upper_q || b < lower_q)) begin
            phase_d[e] = ECA_RECONF;
            rise_d[e] = 1'b0;
            oor_d[e] = 1'b0;
          end
        end
        ECA_IDLE: begin
        end
      endcase
    end
    if (reg_rd) begin
      if (reg_idx < `ECA_IDX_TIME0) begin
        rdata_d = {2'b00, cur_q[reg_idx[3:0]]};
      end else if (reg_idx < `ECA_IDX_UPPER) begin
        rdata_d = {1'b0, tpair_q[3'(reg_idx - `ECA_IDX_TIME0)][6:4], 1'b0,
                   tpair_q[3'(reg_idx - `ECA_IDX_TIME0)][2:0]};
      end else if (reg_idx == `ECA_IDX_UPPER) begin
        rdata_d = upper_q;
      end else if (reg_idx == `ECA_IDX_TARGET) begin
        rdata_d = target_q;
      end else if (reg_idx == `ECA_IDX_LOWER) begin
        rdata_d = lower_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // drive settings for the electrode the front end is about to charge
  always_comb begin
    logic [2:0] t;
    t = own_time(tpair_q[drive_sel[3:1]], drive_sel[0]);
    if (t == `ECA_CODE_OFF) begin
      t = charge_time_code;
    end
    drive_d.enable = (cur_q[drive_sel] != `ECA_RST_CUR);
    drive_d.current = cur_q[drive_sel];
    drive_d.time_code = t;
    drive_d.cycles = time_cycles(t);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `ECA_NUM_ELE; i++) begin
        cur_q[i] <= `ECA_RST_CUR;
        phase_q[i] <= ECA_IDLE;
      end
      for (int i = 0; i < `ECA_NUM_PAIR; i++) begin
        tpair_q[i] <= `ECA_RST_TPAIR;
      end
      rise_q <= '0;
      oor_q <= '0;
      upper_q <= `ECA_RST_LIMIT;
      target_q <= `ECA_RST_LIMIT;
      lower_q <= `ECA_RST_LIMIT;
      initial_conf_fail_flag_q <= 1'b0;
      reconf_fail_flag_q <= 1'b0;
      rdata_q <= 8'h00;
      drive_q <= '0;
    end else begin
      cur_q <= cur_d;
      phase_q <= phase_d;
      tpair_q <= tpair_d;
      rise_q <= rise_d;
      oor_q <= oor_d;
      upper_q <= upper_d;
      target_q <= target_d;
      lower_q <= lower_d;
      initial_conf_fail_flag_q <= initial_conf_fail_flag_d;
      reconf_fail_flag_q <= reconf_fail_flag_d;
      rdata_q <= rdata_d;
      drive_q <= drive_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign drive = drive_q;
  assign out_of_range_flag = oor_q;
  assign initial_conf_fail_flag = initial_conf_fail_flag_q;
  assign reconf_fail_flag = reconf_fail_flag_q;

  // a search measurement on electrode e that is above the ceiling
  sequence s_high_in_search;
    autoconf_enable && meas.valid && meas.ele < 4'(`ECA_NUM_ELE) && !reg_wr &&
    (phase_q[meas.ele] inside {ECA_INIT, ECA_RECONF}) && meas.baseline > upper_q &&
    cur_q[meas.ele] > 6'h01;
  endsequence

  AST_ZERO_CUR_OFF: assert property (@(posedge clk) disable iff (reset)
    drive.current == 6'h00 |-> !drive.enable)
    else $error("zero current code still enables charging");
  AST_CUR_PASS: assert property (@(posedge clk) disable iff (reset)
    drive.enable |-> drive.current == $past(cur_q[drive_sel]))
    else $error("drive current differs from the electrode code");
  AST_TIME_GLOBAL: assert property (@(posedge clk) disable iff (reset)
    own_time(tpair_q[drive_sel[3:1]], drive_sel[0]) == 3'h0 && $stable(tpair_q[drive_sel[3:1]])
    |=> drive.time_code == $past(charge_time_code))
    else $error("zero time code did not take the global time");
  AST_TIME_CYC: assert property (@(posedge clk) disable iff (reset)
    drive.time_code == 3'h7 |-> drive.cycles == 13'h1900)
    else $error("code 7 is not 32 us of cycles");
  AST_STEP_DOWN: assert property (@(posedge clk) disable iff (reset)
    s_high_in_search |=> cur_q[$past(meas.ele)] == $past(cur_q[meas.ele]) - 6'h01)
    else $error("baseline above ceiling did not lower the current");
  AST_STEP_UP: assert property (@(posedge clk) disable iff (reset)
    autoconf_enable && meas.valid && meas.ele < 4'(`ECA_NUM_ELE) && !reg_wr &&
    phase_q[meas.ele] == ECA_INIT && meas.baseline < lower_q && cur_q[meas.ele] < 6'h3F
    |=> cur_q[$past(meas.ele)] == $past(cur_q[meas.ele]) + 6'h01)
    else $error("baseline below floor did not raise the current");
  AST_IDLE_OFF: assert property (@(posedge clk) disable iff (reset)
    !autoconf_enable |=> phase_q[0] == ECA_IDLE && phase_q[11] == ECA_IDLE)
    else $error("search active with configuration disabled");
  AST_RECONF: assert property (@(posedge clk) disable iff (reset)
    autoconf_enable && reconf_enable && meas.valid && meas.ele < 4'(`ECA_NUM_ELE) &&
    phase_q[meas.ele] == ECA_DONE && meas.baseline > upper_q
    |=> phase_q[$past(meas.ele)] == ECA_RECONF)
    else $error("drift outside the limits did not restart the search");
  AST_FAIL_FLAGS: assert property (@(posedge clk) disable iff (reset)
    $rose(oor_q[0]) |-> initial_conf_fail_flag || reconf_fail_flag)
    else $error("out of range without a cause flag");
  AST_RD_UPPER_ZERO: assert property (@(posedge clk) disable iff (reset)
    $past(reg_rd) && $past(reg_idx) < 5'h0C |-> reg_rdata[7:6] == 2'b00)
    else $error("unused current bits read nonzero");

endmodule

`default_nettype wire

// File: test/eca_frontend_model.sv
// front-end model: turns the selected electrode's drive settings into a baseline
// assumes drive comes from the block and clk from the bench; the bench picks the electrode and gain
`timescale 1ns/1ps
`default_nettype none

module eca_frontend_model
  import eca_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire eca_drive_t drive,
  input  wire logic [7:0] gain,
  input  wire logic [3:0] ele,
  output eca_meas_t       meas
);
  logic [13:0] prod;

  assign prod = drive.enable ? drive.current * gain : 14'h0000;

  initial meas = '0;

  // outside a result the lines flip so a stale baseline can never pass
  always @(posedge clk) begin
    if (fire) begin
      meas <= {1'b1, ele, (prod > 14'h00FF) ? 8'hFF : prod[7:0]};
    end else begin
      meas <= {1'b0, ~meas.ele, ~meas.baseline};
    end
  end
endmodule

`default_nettype wire

// File: test/eca_charge_autoconf_test.sv
// self-checking bench: register port, drive settings and the baseline search
// assumes the front-end model answers a fire pulse with one result a cycle later
`timescale 1ns/1ps
`default_nettype none
`include "eca_defines.svh"

module eca_charge_autoconf_test
  import eca_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        autoconf_enable = 1'b0, reconf_enable = 1'b0, fail_flags_clear = 1'b0;
  logic        fire = 1'b0, initial_conf_fail_flag, reconf_fail_flag;
  logic [4:0]  reg_idx = 5'h00;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, gain = 8'h0A, v;
  logic [2:0]  charge_time_code = 3'h3;
  logic [3:0]  drive_sel = 4'h0;
  logic [11:0] out_of_range_flag;
  eca_meas_t   meas;
  eca_drive_t  drive;
  int          n_errors = 0, check_count = 0, c;

  always #2.5 clk = ~clk;

  eca_charge_autoconf eca_charge_autoconf_inst (.clk(clk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .autoconf_enable(autoconf_enable), .reconf_enable(reconf_enable),
    .charge_time_code(charge_time_code), .fail_flags_clear(fail_flags_clear), .meas(meas),
    .drive_sel(drive_sel), .drive(drive), .out_of_range_flag(out_of_range_flag),
    .initial_conf_fail_flag(initial_conf_fail_flag), .reconf_fail_flag(reconf_fail_flag));
  eca_frontend_model eca_frontend_model_inst (.clk(clk), .fire(fire), .drive(drive),
    .gain(gain), .ele(drive_sel), .meas(meas));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1; reg_idx = i; reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [4:0] i, output logic [7:0] d);
    @(posedge clk);
    #1 reg_rd = 1'b1; reg_idx = i;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask

  task automatic sel(input logic [3:0] e);
    @(posedge clk);
    #1 drive_sel = e;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // one baseline result for electrode e, then time for the code and drive to follow
  task automatic measure(input logic [3:0] e);
    sel(e);
    fire = 1'b1;
    @(posedge clk);
    #1 fire = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 21; i++) begin
      rd(5'(i), v);
      check(v, 8'h00);
    end
    wr(`ECA_IDX_CUR0, 8'hFF);
    rd(`ECA_IDX_CUR0, v);
    check(v, 8'h3F);
    wr(`ECA_IDX_TIME0, 8'hFF);
    rd(`ECA_IDX_TIME0, v);
    check(v, 8'h77);
    wr(`ECA_IDX_UPPER, 8'h9C);
    wr(`ECA_IDX_TARGET, 8'h8C);
    wr(`ECA_IDX_LOWER, 8'h65);
    rd(`ECA_IDX_UPPER, v);
    check(v, 8'h9C);
    rd(`ECA_IDX_TARGET, v);
    check(v, 8'h8C);
    rd(`ECA_IDX_LOWER, v);
    check(v, 8'h65);
    wr(5'h15, 8'hFF);
    rd(5'h15, v);
    check(v, 8'h00);
    // electrode 0 takes the low field, electrode 1 the high one; code 0 means global
    for (int k = 0; k < 8; k++) begin
      wr(`ECA_IDX_TIME0, {1'b0, 3'(7 - k), 1'b0, 3'(k)});
      c = (k == 0) ? 3 : k;
      sel(4'h0);
      check(drive.time_code, c);
      check(drive.cycles, 100 << (c - 1));
      sel(4'h1);
      c = (k == 7) ? 3 : 7 - k;
      check(drive.time_code, c);
      check(drive.cycles, 100 << (c - 1));
    end
    sel(4'h0);
    check({drive.enable, drive.current}, 7'h7F);
    wr(`ECA_IDX_CUR0, 8'h00);
    sel(4'h0);
    check(drive.enable, 1'b0);
    wr(5'h02, 8'h05);
    measure(4'h2);
    rd(5'h02, v);
    check(v, 8'h05);
    // search for electrode 0: baseline is ten per microampere
    @(posedge clk);
    #1 autoconf_enable = 1'b1;
    rd(`ECA_IDX_CUR0, v);
    check(v, 8'h01);
    for (int n = 0; n < 20; n++) measure(4'h0);
    rd(`ECA_IDX_CUR0, v);
    check(v, 8'h0E);
    check(out_of_range_flag[0], 1'b0);
    // electrode 1 overshoots the upper limit already at the lowest current
    gain = 8'hC8;
    measure(4'h1);
    check(out_of_range_flag[1], 1'b1);
    check({initial_conf_fail_flag, reconf_fail_flag}, 2'b10);
    fail_flags_clear = 1'b1;
    @(posedge clk);
    #1 fail_flags_clear = 1'b0;
    @(posedge clk);
    #1 check(initial_conf_fail_flag, 1'b0);
    // baseline pinned high: reconfiguration starts, walks down and gives up
    @(posedge clk);
    #1 reconf_enable = 1'b1;
    gain = 8'hFF;
    // one result enters reconfiguration, 13 walk 14 down to 1, the last one fails
    for (int n = 0; n < 15; n++) measure(4'h0);
    check({initial_conf_fail_flag, reconf_fail_flag}, 2'b01);
    check(out_of_range_flag[0], 1'b1);
    conclude();
  end
endmodule

`default_nettype wire
